//--- src/emx_alu.sv
// extended memory alu datapath: working register, flags, memory sequencing
//
// How it works
// - invert memory byte, write back to same place, update zero only.
// - invert memory byte into working register, memory untouched, zero only.
// - decimal fixup adds six to low nibble if above nine or half spill.
// - decimal fixup adds six to high nibble if above nine or carry set.
// - fixup result is wreg plus 00/06/60/66 into memory; carry only.
// - minus one on memory byte, to memory or wreg; zero only.
// - plus one on memory byte, to memory or wreg; zero only.
// - move memory byte into working register, no flag changes.
// - move working register into memory byte, no flag changes.
// - OR of wreg and memory, to wreg or memory; zero only.
// - rotate up, bit 7 into bit 0, to memory or wreg; no flags.
// - rotate up through carry; carry into bit 0, bit 7 into carry.
// - rotate down, bit 0 into bit 7, to memory or wreg; no flags.
// - rotate down through carry; carry into bit 7, bit 0 into carry.
// - subtract with borrow into wreg, all six arithmetic flags updated.
// - memory form of subtract with borrow, same flags, result to memory.
// - carry cleared on negative difference, set on zero or positive.
// - full flat address reaches every data memory section, no banking.
`timescale 1ns/1ps
module emx_alu
  import emx_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // operation request from the sequencer
  input wire logic opValid,
  input wire emx_pkg::emx_req_t opReq,
  output logic opReady,
  output logic opDone,
  // preset of working register and flags by the sequencer
  input wire logic presetLoad,
  input wire logic [emx_pkg::DATA_W-1:0] presetWreg,
  input wire emx_pkg::emx_flags_t presetFlags,
  // data memory port
  output emx_pkg::emx_mem_t memPort,
  input wire logic [emx_pkg::DATA_W-1:0] memRdData,
  // architectural state
  output logic [emx_pkg::DATA_W-1:0] workingRegister,
  output emx_pkg::emx_flags_t statusFlags
);
  typedef struct packed {
    emx_state_t state;
    emx_op_t op;
    logic ready;
    logic done;
    emx_mem_t mem;
    logic [DATA_W-1:0] wreg;
    emx_flags_t flags;
  } emx_core_t;

  emx_core_t cur;
  emx_core_t next_cur;

  logic [DATA_W-1:0] subDiff;
  emx_flags_t subFlags;

  // subtractor reads the port directly; read data stands only in the calc cycle
  emx_borrow_sub u_sub (
    .minuend(cur.wreg),
    .subtrahend(memRdData),
    .carryIn(cur.flags.carry),
    .chainIn(cur.flags.chainedNil),
    .diff(subDiff),
    .flags(subFlags)
  );

  // ops that never look at memory skip the read phase
  function automatic logic needsRead(input emx_op_t op);
    needsRead = !(op == OP_DECIMAL_FIXUP_TO_MEM || op == OP_FAR_MOVE_TO_MEM);
  endfunction

  // decimal fixup of the working register, high nibble judged on its original value
  logic [DATA_W-1:0] fixAdj;
  logic [DATA_W:0] fixSum;
  logic fixLow;
  logic fixHigh;

  always_comb begin
    fixLow = (cur.wreg[NIB_W-1:0] > NIB_LIMIT) || cur.flags.halfSpill;
    fixHigh = (cur.wreg[DATA_W-1:NIB_HI_LSB] > NIB_LIMIT) || cur.flags.carry;
    unique case ({fixHigh, fixLow})
      2'b00: fixAdj = ADJ_NONE;
      2'b01: fixAdj = ADJ_LOW;
      2'b10: fixAdj = ADJ_HIGH;
      2'b11: fixAdj = ADJ_BOTH;
    endcase
    fixSum = {1'b0, cur.wreg} + {1'b0, fixAdj};
  end

  // rotations shared by both destinations of each rotate op
  logic [DATA_W-1:0] rotUp;
  logic [DATA_W-1:0] rotDown;
  logic [DATA_W-1:0] rotUpCarry;
  logic [DATA_W-1:0] rotDownCarry;

  always_comb begin
    rotUp = {memRdData[MSB-1:LSB], memRdData[MSB]};
    rotDown = {memRdData[LSB], memRdData[MSB:LSB+1]};
    rotUpCarry = {memRdData[MSB-1:LSB], cur.flags.carry};
    rotDownCarry = {cur.flags.carry, memRdData[MSB:LSB+1]};
  end

  logic [DATA_W-1:0] res;
  logic toMem;
  logic toWreg;
  logic setZero;

  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    next_cur.mem.read = 1'b0;
    next_cur.mem.write = 1'b0;
    res = BYTE_ZERO;
    toMem = 1'b0;
    toWreg = 1'b0;
    setZero = 1'b0;

    unique case (cur.state)
      ST_IDLE: begin
        if (opValid) begin
          next_cur.op = opReq.op;
          next_cur.mem.addr = opReq.addr;
          next_cur.ready = 1'b0;
          if (needsRead(opReq.op)) begin
            next_cur.mem.read = 1'b1;
            next_cur.state = ST_READ;
          end else begin
            next_cur.state = ST_CALC;
          end
        end else if (presetLoad) begin
          // preset only while idle so it cannot tear an operation
          next_cur.wreg = presetWreg;
          next_cur.flags = presetFlags;
        end
      end

      ST_READ: begin
        // memory answers one edge after the read strobe
        next_cur.state = ST_CALC;
      end

      ST_CALC: begin
        unique case (cur.op)
          OP_MEM_INVERT: begin
            res = ~memRdData;
            toMem = 1'b1;
            setZero = 1'b1;
          end

          OP_MEM_INVERT_TO_WREG: begin
            res = ~memRdData;
            toWreg = 1'b1;
            setZero = 1'b1;
          end

          OP_DECIMAL_FIXUP_TO_MEM: begin
            res = fixSum[DATA_W-1:0];
            toMem = 1'b1;
            // carry once set stays set so multi-byte sums chain
            next_cur.flags.carry = cur.flags.carry | fixSum[DATA_W];
          end

          OP_MEM_MINUS_ONE: begin
            res = memRdData - BYTE_ONE;
            toMem = 1'b1;
            setZero = 1'b1;
          end

          OP_MEM_MINUS_ONE_TO_WREG: begin
            res = memRdData - BYTE_ONE;
            toWreg = 1'b1;
            setZero = 1'b1;
          end

          OP_MEM_PLUS_ONE: begin
            res = memRdData + BYTE_ONE;
            toMem = 1'b1;
            setZero = 1'b1;
          end

          OP_MEM_PLUS_ONE_TO_WREG: begin
            res = memRdData + BYTE_ONE;
            toWreg = 1'b1;
            setZero = 1'b1;
          end

          OP_FAR_MOVE_TO_WREG: begin
            res = memRdData;
            toWreg = 1'b1;
          end

          OP_FAR_MOVE_TO_MEM: begin
            res = cur.wreg;
            toMem = 1'b1;
          end

          OP_FAR_BITWISE_UNION: begin
            res = cur.wreg | memRdData;
            toWreg = 1'b1;
            setZero = 1'b1;
          end

          OP_FAR_BITWISE_UNION_TO_MEM: begin
            res = cur.wreg | memRdData;
            toMem = 1'b1;
            setZero = 1'b1;
          end

          OP_MEM_ROTATE_UP: begin
            res = rotUp;
            toMem = 1'b1;
          end

          OP_MEM_ROTATE_UP_TO_WREG: begin
            res = rotUp;
            toWreg = 1'b1;
          end

          OP_MEM_ROTATE_UP_VIA_FLAG: begin
            res = rotUpCarry;
            next_cur.flags.carry = memRdData[MSB];
            toMem = 1'b1;
          end

          OP_MEM_ROTATE_UP_VIA_FLAG_TO_WREG: begin
            res = rotUpCarry;
            next_cur.flags.carry = memRdData[MSB];
            toWreg = 1'b1;
          end

          OP_MEM_ROTATE_DOWN: begin
            res = rotDown;
            toMem = 1'b1;
          end

          OP_MEM_ROTATE_DOWN_TO_WREG: begin
            res = rotDown;
            toWreg = 1'b1;
          end

          OP_MEM_ROTATE_DOWN_VIA_FLAG: begin
            res = rotDownCarry;
            next_cur.flags.carry = memRdData[LSB];
            toMem = 1'b1;
          end

          OP_MEM_ROTATE_DOWN_VIA_FLAG_TO_WREG: begin
            res = rotDownCarry;
            next_cur.flags.carry = memRdData[LSB];
            toWreg = 1'b1;
          end

          OP_FAR_SUBTRACT_BORROW: begin
            res = subDiff;
            toWreg = 1'b1;
            next_cur.flags = subFlags;
          end

          OP_FAR_SUBTRACT_BORROW_TO_MEM: begin
            res = subDiff;
            toMem = 1'b1;
            next_cur.flags = subFlags;
          end

          default: begin
            // undefined op code: finish with no effect
            res = cur.wreg;
          end
        endcase

        if (setZero) begin
          next_cur.flags.zero = (res == BYTE_ZERO);
        end
        if (toWreg) begin
          next_cur.wreg = res;
        end
        if (toMem) begin
          next_cur.mem.write = 1'b1;
          next_cur.mem.wrData = res;
        end
        next_cur.done = 1'b1;
        next_cur.ready = 1'b1;
        next_cur.state = ST_IDLE;
      end

      default: begin
        // illegal state code recovers to idle
        next_cur.state = ST_IDLE;
        next_cur.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cur.state <= ST_IDLE;
      cur.op <= OP_MEM_INVERT;
      cur.ready <= 1'b1;
      cur.done <= 1'b0;
      cur.mem.read <= 1'b0;
      cur.mem.write <= 1'b0;
      cur.mem.addr <= ADDR_ZERO;
      cur.mem.wrData <= BYTE_ZERO;
      cur.wreg <= WREG_RESET;
      cur.flags <= FLAGS_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from the state flops
  assign opReady = cur.ready;
  assign opDone = cur.done;
  assign memPort = cur.mem;
  assign workingRegister = cur.wreg;
  assign statusFlags = cur.flags;
endmodule

//--- src/emx_pkg.sv
// shared types and constants for the extended memory alu datapath
package emx_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int NIB_W = 4;
  localparam int MSB = DATA_W - 1;
  localparam int LSB = 0;
  localparam int NIB_HI_LSB = NIB_W;

  localparam logic [NIB_W-1:0] NIB_LIMIT = 4'h9;
  localparam logic [DATA_W-1:0] ADJ_NONE = 8'h00;
  localparam logic [DATA_W-1:0] ADJ_LOW = 8'h06;
  localparam logic [DATA_W-1:0] ADJ_HIGH = 8'h60;
  localparam logic [DATA_W-1:0] ADJ_BOTH = 8'h66;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 12'h000;
  localparam logic [DATA_W-1:0] WREG_RESET = 8'h00;

  typedef enum logic [4:0] {
    OP_MEM_INVERT = 5'h00,
    OP_MEM_INVERT_TO_WREG = 5'h01,
    OP_DECIMAL_FIXUP_TO_MEM = 5'h02,
    OP_MEM_MINUS_ONE = 5'h03,
    OP_MEM_MINUS_ONE_TO_WREG = 5'h04,
    OP_MEM_PLUS_ONE = 5'h05,
    OP_MEM_PLUS_ONE_TO_WREG = 5'h06,
    OP_FAR_MOVE_TO_WREG = 5'h07,
    OP_FAR_MOVE_TO_MEM = 5'h08,
    OP_FAR_BITWISE_UNION = 5'h09,
    OP_FAR_BITWISE_UNION_TO_MEM = 5'h0a,
    OP_MEM_ROTATE_UP = 5'h0b,
    OP_MEM_ROTATE_UP_TO_WREG = 5'h0c,
    OP_MEM_ROTATE_UP_VIA_FLAG = 5'h0d,
    OP_MEM_ROTATE_UP_VIA_FLAG_TO_WREG = 5'h0e,
    OP_MEM_ROTATE_DOWN = 5'h0f,
    OP_MEM_ROTATE_DOWN_TO_WREG = 5'h10,
    OP_MEM_ROTATE_DOWN_VIA_FLAG = 5'h11,
    OP_MEM_ROTATE_DOWN_VIA_FLAG_TO_WREG = 5'h12,
    OP_FAR_SUBTRACT_BORROW = 5'h13,
    OP_FAR_SUBTRACT_BORROW_TO_MEM = 5'h14
  } emx_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_CALC = 2'b10
  } emx_state_t;

  // status flags; carry is the unsigned spill flag
  typedef struct packed {
    logic zero;
    logic carry;
    logic halfSpill;
    logic signedSpill;
    logic auxSigned;
    logic chainedNil;
  } emx_flags_t;

  localparam emx_flags_t FLAGS_RESET = '0;

  typedef struct packed {
    emx_op_t op;
    logic [ADDR_W-1:0] addr;
  } emx_req_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
  } emx_mem_t;
endpackage

//--- src/emx_borrow_sub.sv
// subtract with borrow and its six flags
`timescale 1ns/1ps
module emx_borrow_sub
  import emx_pkg::*;
(
  // operands
  input wire logic [emx_pkg::DATA_W-1:0] minuend,
  input wire logic [emx_pkg::DATA_W-1:0] subtrahend,
  input wire logic carryIn,
  input wire logic chainIn,
  // results
  output logic [emx_pkg::DATA_W-1:0] diff,
  output emx_pkg::emx_flags_t flags
);
  logic [DATA_W:0] wide;
  logic [NIB_W:0] lowWide;
  logic borrowIn;

  always_comb begin
    borrowIn = ~carryIn;
    wide = {1'b0, minuend} - {1'b0, subtrahend} - {{DATA_W{1'b0}}, borrowIn};
    lowWide = {1'b0, minuend[NIB_W-1:0]} - {1'b0, subtrahend[NIB_W-1:0]}
      - {{NIB_W{1'b0}}, borrowIn};
    diff = wide[DATA_W-1:0];
    flags.carry = ~wide[DATA_W];
    flags.halfSpill = ~lowWide[NIB_W];
    flags.zero = (diff == BYTE_ZERO);
    flags.signedSpill = (minuend[MSB] != subtrahend[MSB]) && (diff[MSB] != minuend[MSB]);
    // true sign of the difference, valid even on overflow
    flags.auxSigned = flags.signedSpill ^ diff[MSB];
    // chained zero only stays set while every byte of a chain was zero
    flags.chainedNil = flags.zero & chainIn;
  end
endmodule

//--- verif/emx_alu_sva.sv
// concurrent checks on the extended memory alu ports
`timescale 1ns/1ps
module emx_alu_sva
  import emx_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // request side
  input wire logic opValid,
  input wire emx_pkg::emx_req_t opReq,
  input wire logic opReady,
  input wire logic opDone,
  input wire logic presetLoad,
  input wire logic [emx_pkg::DATA_W-1:0] presetWreg,
  input wire emx_pkg::emx_flags_t presetFlags,
  // memory and state
  input wire emx_pkg::emx_mem_t memPort,
  input wire logic [emx_pkg::DATA_W-1:0] memRdData,
  input wire logic [emx_pkg::DATA_W-1:0] workingRegister,
  input wire emx_pkg::emx_flags_t statusFlags
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // fixup and store skip the memory read
  wire noRd = opReq.op == OP_DECIMAL_FIXUP_TO_MEM || opReq.op == OP_FAR_MOVE_TO_MEM;
  sequence sTake;
    opValid && opReady;
  endsequence
  sequence sRead;
    memPort.read && !opReady;
  endsequence
  AST_RD_ADDR: assert property (sTake ##0 !noRd |=> sRead ##0 memPort.addr == $past(opReq.addr))
    else $error("read address differs from request");
  AST_RD_DONE: assert property (sTake ##0 !noRd |=> sRead ##1 !opDone ##1 opDone)
    else $error("read op did not finish on time");
  AST_NR_DONE: assert property (sTake ##0 noRd |=> !memPort.read ##1 opDone && memPort.write)
    else $error("fixup or store did not write on time");
  AST_WR_DONE: assert property (memPort.write |-> opDone)
    else $error("write outside done cycle");
  AST_MOVE_FLAGS: assert property (sTake ##0 opReq.op == OP_FAR_MOVE_TO_WREG |=> $stable(statusFlags)[*3])
    else $error("move changed flags");
  AST_STORE: assert property (sTake ##0 opReq.op == OP_FAR_MOVE_TO_MEM |-> ##2 memPort.wrData == $past(workingRegister, 2))
    else $error("store data differs from working register");
  AST_UNION_ZERO: assert property (sTake ##0 opReq.op == OP_FAR_BITWISE_UNION |-> ##3 statusFlags.zero == (workingRegister == 8'h00))
    else $error("zero flag wrong after union");
  AST_ROT_FLAGS: assert property (sTake ##0 opReq.op == OP_MEM_ROTATE_UP |=> $stable(statusFlags)[*3])
    else $error("plain rotate changed flags");
  AST_INV_KEEP: assert property (sTake ##0 opReq.op == OP_MEM_INVERT |=> $stable(workingRegister)[*3])
    else $error("memory invert touched working register");
endmodule

bind emx_alu emx_alu_sva u_sva (.mclk(mclk), .reset_n(reset_n), .opValid(opValid), .opReq(opReq),
  .opReady(opReady), .opDone(opDone), .presetLoad(presetLoad), .presetWreg(presetWreg),
  .presetFlags(presetFlags), .memPort(memPort), .memRdData(memRdData),
  .workingRegister(workingRegister), .statusFlags(statusFlags));

//--- verif/emx_mem_model.sv
// data memory partner: one cycle read latency, scrambled data outside the valid cycle
`timescale 1ns/1ps
module emx_mem_model
  import emx_pkg::*;
(
  // clock
  input wire logic mclk,
  // memory port
  input wire emx_pkg::emx_mem_t memPort,
  output logic [emx_pkg::DATA_W-1:0] memRdData
);
  logic [7:0] ram [0:4095];
  initial memRdData = 8'h00;
  // stale data is inverted so a late sample cannot pass by luck
  always @(posedge mclk) begin
    memRdData <= memPort.read ? ram[memPort.addr] : ~memRdData;
    if (memPort.write) begin
      ram[memPort.addr] <= memPort.wrData;
    end
  end
endmodule

//--- verif/tb.sv
// self-checking bench for the extended memory alu
`timescale 1ns/1ps
module tb;
  import emx_pkg::*;
  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [7:0] data;
    logic [7:0] wreg;
    emx_flags_t flags;
  } emx_note_t;
  logic mclk, reset_n, opValid, opReady, opDone, presetLoad;
  emx_req_t opReq;
  logic [7:0] presetWreg, memRdData, workingRegister, sWreg, sMem [0:4095];
  emx_flags_t presetFlags, statusFlags, sFlags;
  emx_mem_t memPort;
  emx_note_t q[$];
  emx_note_t g;
  int n_mismatch = 0;
  int num_checks = 0;
  emx_alu dut (.mclk(mclk), .reset_n(reset_n), .opValid(opValid), .opReq(opReq),
    .opReady(opReady), .opDone(opDone), .presetLoad(presetLoad), .presetWreg(presetWreg),
    .presetFlags(presetFlags), .memPort(memPort), .memRdData(memRdData),
    .workingRegister(workingRegister), .statusFlags(statusFlags));
  emx_mem_model mem (.mclk(mclk), .memPort(memPort), .memRdData(memRdData));
  always #2.5 mclk = ~mclk;
  function automatic logic [7:0] pick();
    case ($urandom % 3)
      0: return 8'h00;
      1: return 8'hff;
      default: return 8'($urandom);
    endcase
  endfunction
  function automatic emx_note_t ref_op(emx_op_t op, logic [11:0] a, logic [7:0] m, w,
      emx_flags_t f);
    emx_note_t n;
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    n = '{1'b0, 12'h000, 8'h00, w, f};
    s = 9'h000;
    case (op)
      OP_MEM_INVERT, OP_MEM_INVERT_TO_WREG: r = ~m;
      OP_MEM_MINUS_ONE, OP_MEM_MINUS_ONE_TO_WREG: r = m - 8'h01;
      OP_MEM_PLUS_ONE, OP_MEM_PLUS_ONE_TO_WREG: r = m + 8'h01;
      OP_FAR_MOVE_TO_WREG: r = m;
      OP_FAR_MOVE_TO_MEM: r = w;
      OP_FAR_BITWISE_UNION, OP_FAR_BITWISE_UNION_TO_MEM: r = w | m;
      OP_MEM_ROTATE_UP, OP_MEM_ROTATE_UP_TO_WREG: r = {m[6:0], m[7]};
      OP_MEM_ROTATE_DOWN, OP_MEM_ROTATE_DOWN_TO_WREG: r = {m[0], m[7:1]};
      OP_MEM_ROTATE_UP_VIA_FLAG, OP_MEM_ROTATE_UP_VIA_FLAG_TO_WREG: begin
        r = {m[6:0], f.carry};
        n.flags.carry = m[7];
      end
      OP_MEM_ROTATE_DOWN_VIA_FLAG, OP_MEM_ROTATE_DOWN_VIA_FLAG_TO_WREG: begin
        r = {f.carry, m[7:1]};
        n.flags.carry = m[0];
      end
      OP_DECIMAL_FIXUP_TO_MEM: begin
        s = {1'b0, w} + {((w[7:4] > 4'h9) || f.carry) ? 4'h6 : 4'h0,
          ((w[3:0] > 4'h9) || f.halfSpill) ? 4'h6 : 4'h0};
        r = s[7:0];
        n.flags.carry = f.carry | s[8];
      end
      OP_FAR_SUBTRACT_BORROW, OP_FAR_SUBTRACT_BORROW_TO_MEM: begin
        s = {1'b0, w} - {1'b0, m} - {8'h00, ~f.carry};
        h = {1'b0, w[3:0]} - {1'b0, m[3:0]} - {4'h0, ~f.carry};
        r = s[7:0];
        n.flags.signedSpill = (w[7] ^ m[7]) & (w[7] ^ r[7]);
        n.flags = '{r == 8'h00, ~s[8], ~h[4], n.flags.signedSpill,
          n.flags.signedSpill ^ r[7], (r == 8'h00) & f.chainedNil};
      end
      // undefined code finishes with no effect
      default: r = w;
    endcase
    if (op inside {[OP_MEM_INVERT:OP_MEM_INVERT_TO_WREG], [OP_MEM_MINUS_ONE:OP_MEM_PLUS_ONE_TO_WREG],
        OP_FAR_BITWISE_UNION, OP_FAR_BITWISE_UNION_TO_MEM}) begin
      n.flags.zero = (r == 8'h00);
    end
    if (op inside {OP_MEM_INVERT, OP_DECIMAL_FIXUP_TO_MEM, OP_MEM_MINUS_ONE, OP_MEM_PLUS_ONE,
        OP_FAR_MOVE_TO_MEM, OP_FAR_BITWISE_UNION_TO_MEM, OP_MEM_ROTATE_UP, OP_MEM_ROTATE_DOWN,
        OP_MEM_ROTATE_UP_VIA_FLAG, OP_MEM_ROTATE_DOWN_VIA_FLAG, OP_FAR_SUBTRACT_BORROW_TO_MEM}) begin
      n.wr = 1'b1;
      n.addr = a;
      n.data = r;
    end else begin
      n.wreg = r;
    end
    return n;
  endfunction
  task automatic cmp(input logic [63:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic go(input emx_op_t op, input logic [11:0] a);
    emx_note_t n;
    n = ref_op(op, a, sMem[a], sWreg, sFlags);
    opValid <= 1'b1;
    opReq <= '{op, a};
    do @(posedge mclk); while (opReady !== 1'b1);
    q.push_back(n);
    if (n.wr) sMem[a] = n.data;
    sWreg = n.wreg;
    sFlags = n.flags;
  endtask
  task automatic preset(input logic [11:0] a);
    opValid <= 1'b0;
    do @(posedge mclk); while (opReady !== 1'b1);
    sWreg = pick();
    sFlags = emx_flags_t'(6'($urandom));
    presetLoad <= 1'b1;
    presetWreg <= sWreg;
    presetFlags <= sFlags;
    @(posedge mclk);
    presetLoad <= 1'b0;
    sMem[a] = pick();
    mem.ram[a] = sMem[a];
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // results are paired with the oldest expectation as opDone appears
  always @(posedge mclk) begin
    if (reset_n && opDone === 1'b1) begin
      g = '{memPort.write, memPort.write ? memPort.addr : 12'h000,
        memPort.write ? memPort.wrData : 8'h00, workingRegister, statusFlags};
      if (q.size() == 0) cmp(64'h1, 64'h0, "unexpected done");
      else cmp(64'(g), 64'(q.pop_front()), "result");
    end
  end
  initial begin
    #100000;
    n_mismatch++;
    $display("wrong value at %0t: timeout", $time);
    give_verdict();
  end
  initial begin : main
    logic [11:0] a;
    mclk = 0;
    reset_n = 0;
    opValid = 0;
    opReq = '0;
    presetLoad = 0;
    presetWreg = 0;
    presetFlags = '0;
    sWreg = 0;
    sFlags = '0;
    void'($urandom(32'h76350acf));
    for (int i = 0; i < 4096; i++) begin
      sMem[i] = pick();
      mem.ram[i] = sMem[i];
    end
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    #1;
    cmp(64'({opReady, opDone, memPort, workingRegister, 6'(statusFlags)}),
      64'h0000_0020_0000_0000, "reset");
    $display("test reset done");
    // back to back ops on random flat addresses, state re-seeded every fourth op
    // code 21 is undefined and must finish with no effect
    for (int i = 0; i <= 21; i++) begin
      for (int k = 0; k < 12; k++) begin
        a = 12'($urandom);
        if (k % 4 == 0) preset(a);
        go(emx_op_t'(5'(i)), a);
      end
      $display("test op %0d done", i);
    end
    opValid <= 1'b0;
    repeat (10) @(posedge mclk);
    cmp(64'(q.size()), 64'h0, "pending results");
    give_verdict();
  end
endmodule
